// ===== src/aec_engine.sv
// electronic codebook block-cipher engine with byte ports and result buffer
`timescale 1ns/100ps
`include "aec_consts.svh"

// ---------------------------------------------------------------
// result buffer
// ---------------------------------------------------------------
module aec_fifo #(
	parameter int WIDTH = `AEC_FIFO_WIDTH,
	parameter int DEPTH = `AEC_FIFO_DEPTH
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = DEPTH[AW:0];

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire  [AW:0]      level   = wr_ptr - rd_ptr;
	wire              do_push = in_valid & in_ready;
	wire              do_pop  = out_valid & out_ready;

	assign in_ready  = level != FULL;
	assign out_valid = level != '0;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge mclk) begin
		if (rst | flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + {{AW{1'b0}}, do_push};
			rd_ptr <= rd_ptr + {{AW{1'b0}}, do_pop};
		end
	end

	always_ff @(posedge mclk) begin
		if (do_push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end
endmodule

// ---------------------------------------------------------------
// engine
// ---------------------------------------------------------------
module aec_engine
	import aec_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       cfg_wr,
	input  wire logic [7:0] cfg_wdata,
	output logic      [7:0] cfg_rdata,
	input  wire logic       dflow_wr,
	input  wire logic [7:0] dflow_wdata,
	output logic      [7:0] dflow_rdata,
	input  wire logic       key_wr,
	input  wire logic [7:0] key_data,
	input  wire logic       blk_wr,
	input  wire logic [7:0] blk_data,
	input  wire logic       res_rd,
	output logic      [7:0] res_data,
	output logic            res_req,
	output logic            key_req,
	output logic            blk_req,
	output logic            done_irq
);
	// -----------------------------------------------------------
	// field arithmetic
	// -----------------------------------------------------------
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? `AEC_POLY : 8'h00);
		end
		return p;
	endfunction

	function automatic logic [7:0] gfinv(input logic [7:0] a);
		logic [7:0] r;
		logic [7:0] base;
		logic [7:0] e;
		r = `AEC_M1;
		base = a;
		e = `AEC_INV_EXP;
		for (int i = 0; i < 8; i++) begin
			if (e[i]) r = gmul(r, base);
			base = gmul(base, base);
		end
		return r;
	endfunction

	function automatic logic [7:0] sbox(input logic [7:0] a);
		logic [7:0] b;
		b = gfinv(a);
		return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]}
			^ {b[3:0], b[7:4]} ^ `AEC_FWD_AFFINE;
	endfunction

	function automatic logic [7:0] isbox(input logic [7:0] s);
		return gfinv({s[6:0], s[7]} ^ {s[4:0], s[7:5]} ^ {s[1:0], s[7:2]}
			^ `AEC_INV_AFFINE);
	endfunction

	function automatic logic [31:0] mixcol(input logic [31:0] w, input logic inv);
		logic [7:0]  a [4];
		logic [31:0] r;
		for (int i = 0; i < 4; i++) a[i] = w[31-8*i -: 8];
		r = '0;
		for (int i = 0; i < 4; i++) begin
			r[31-8*i -: 8] = inv
				? gmul(a[i], `AEC_ME) ^ gmul(a[(i+1)%4], `AEC_MB)
				  ^ gmul(a[(i+2)%4], `AEC_MD) ^ gmul(a[(i+3)%4], `AEC_M9)
				: gmul(a[i], `AEC_M2) ^ gmul(a[(i+1)%4], `AEC_M3)
				  ^ a[(i+2)%4] ^ a[(i+3)%4];
		end
		return r;
	endfunction

	function automatic logic [7:0] rcon_f(input logic [3:0] q);
		logic [7:0] r;
		r = `AEC_RCON_INIT;
		for (int i = 1; i < 15; i++) begin
			if (i < q) r = gmul(r, `AEC_M2);
		end
		return r;
	endfunction

	// -----------------------------------------------------------
	// configuration and state
	// -----------------------------------------------------------
	aec_state_type state, next_state;
	aec_ksize_type ksz;
	logic          enc;
	logic          en;
	logic          done;
	logic [4:0]    data_cnt, next_data_cnt;
	logic [5:0]    key_cnt, next_key_cnt;
	logic [4:0]    out_cnt, next_out_cnt;
	logic [5:0]    kidx, next_kidx;
	logic [3:0]    kph, next_kph;
	logic [3:0]    kq, next_kq;
	logic [3:0]    rnd, next_rnd;
	logic [127:0]  cs, next_cs;
	logic [31:0]   kw [`AEC_KEY_WORDS];
	logic          res_full;
	logic          res_load;

	// size decode; reserved code runs as the shortest key
	wire [3:0] nk = (ksz == ks_256) ? `AEC_NK_256 : (ksz == ks_192) ? `AEC_NK_192 : `AEC_NK_128;
	wire [3:0] nr = (ksz == ks_256) ? `AEC_NR_256 : (ksz == ks_192) ? `AEC_NR_192 : `AEC_NR_128;
	wire [5:0] tw = (ksz == ks_256) ? `AEC_TW_256 : (ksz == ks_192) ? `AEC_TW_192 : `AEC_TW_128;
	wire [3:0] dq = (ksz == ks_256) ? `AEC_DQ_256 : (ksz == ks_192) ? `AEC_DQ_192 : `AEC_DQ_128;
	wire [5:0] klen = {nk, 2'b00};

	wire soft_rst  = cfg_wr & (cfg_wdata == `AEC_SOFT_RESET);
	wire loading   = state == st_load;
	wire key_take  = key_wr & loading & (key_cnt < klen);
	wire blk_take  = blk_wr & loading & (data_cnt < `AEC_BLOCK_BYTES);
	wire load_full = (key_cnt == klen) & (data_cnt == `AEC_BLOCK_BYTES);
	wire new_block = (key_take | blk_take) & (key_cnt == 6'd0) & (data_cnt == 5'd0);

	// -----------------------------------------------------------
	// key schedule, forward for the cipher key, backward for the inverse key
	// -----------------------------------------------------------
	// cipher key seeds bottom words
	wire [5:0]  key_base = enc ? 6'd0 : tw - {2'b00, nk};
	wire [5:0]  key_widx = key_base + {2'b00, key_cnt[5:2]};
	wire [31:0] kprev    = kw[kidx - 6'd1];
	wire [31:0] ksubrot  = {sbox(kprev[23:16]), sbox(kprev[15:8]), sbox(kprev[7:0]),
		sbox(kprev[31:24])};
	wire [31:0] ksub     = {sbox(kprev[31:24]), sbox(kprev[23:16]), sbox(kprev[15:8]),
		sbox(kprev[7:0])};
	wire [31:0] ktemp    = (kph == 4'd0) ? ksubrot ^ {rcon_f(kq), 24'h000000}
		: ((nk == `AEC_NK_256) && (kph == `AEC_SUB_PHASE)) ? ksub : kprev;
	wire [5:0]  kpair    = kidx - {2'b00, nk};
	wire [5:0]  kw_dst   = enc ? kidx : kpair;
	wire [31:0] kw_val   = kw[enc ? kpair : kidx] ^ ktemp;
	wire        exp_last = enc ? (kidx == tw - 6'd1) : (kidx == {2'b00, nk});

	// -----------------------------------------------------------
	// round datapath, one round per clock
	// -----------------------------------------------------------
	wire [3:0]   kr = enc ? rnd : nr - rnd;
	wire [5:0]   kb = {kr, 2'b00};
	wire [127:0] rk = {kw[kb], kw[kb + 6'd1], kw[kb + 6'd2], kw[kb + 6'd3]};
	logic [127:0] sub_e, sub_d, mix_e, mix_d;

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_byte
			localparam int R  = g % 4;
			localparam int C  = g / 4;
			localparam int SE = 4 * ((C + R) % 4) + R;
			localparam int SD = 4 * ((C - R + 4) % 4) + R;
			assign sub_e[127-8*g -: 8] = sbox(cs[127-8*SE -: 8]);
			assign sub_d[127-8*g -: 8] = isbox(cs[127-8*SD -: 8]);
		end
		for (g = 0; g < 4; g++) begin : g_col
			assign mix_e[127-32*g -: 32] = mixcol(sub_e[127-32*g -: 32], 1'b0);
			assign mix_d[127-32*g -: 32] = mixcol(sub_d[127-32*g -: 32] ^ rk[127-32*g -: 32],
				1'b1);
		end
	endgenerate

	wire [127:0] enc_next = (rnd == 4'd0) ? cs ^ rk : (rnd == nr) ? sub_e ^ rk : mix_e ^ rk;
	wire [127:0] dec_next = (rnd == 4'd0) ? cs ^ rk : (rnd == nr) ? sub_d ^ rk : mix_d;

	// -----------------------------------------------------------
	// result path through the buffer
	// -----------------------------------------------------------
	// core output bypasses xor
	wire [7:0] out_byte = cs[8*(`AEC_LAST_BYTE - out_cnt) +: 8];
	wire       push     = state == st_unload;
	wire       push_rdy;
	wire       fifo_valid;
	wire [7:0] fifo_data;
	wire       res_pop  = res_full & res_rd;
	assign res_load = fifo_valid & (~res_full | res_pop);
	wire       blk_done = push & push_rdy & (out_cnt == `AEC_LAST_BYTE);

	aec_fifo #(
		.WIDTH(`AEC_FIFO_WIDTH),
		.DEPTH(`AEC_FIFO_DEPTH)
	) u_fifo (
		.mclk     (mclk),
		.rst      (rst),
		.flush    (soft_rst),
		.in_valid (push),
		.in_data  (out_byte),
		.in_ready (push_rdy),
		.out_valid(fifo_valid),
		.out_data (fifo_data),
		.out_ready(res_load)
	);

	// -----------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_data_cnt = data_cnt;
		next_key_cnt  = key_cnt;
		next_out_cnt  = out_cnt;
		next_kidx     = kidx;
		next_kph      = kph;
		next_kq       = kq;
		next_rnd      = rnd;
		next_cs       = cs;
		case (state)
			st_idle: begin
				next_data_cnt = 5'd0;
				next_key_cnt  = 6'd0;
				if (en) next_state = st_load;
			end
			st_load: begin
				if (blk_take) begin
					next_cs[8*(`AEC_LAST_BYTE - data_cnt) +: 8] = blk_data;
					next_data_cnt = data_cnt + 5'd1;
				end
				if (key_take) next_key_cnt = key_cnt + 6'd1;
				if (load_full) begin
					next_state = st_expand;
					next_kidx  = enc ? {2'b00, nk} : tw - 6'd1;
					next_kph   = enc ? 4'd0 : `AEC_DEC_PHASE;
					next_kq    = enc ? 4'd1 : dq;
				end
			end
			st_expand: begin
				if (enc) begin
					next_kidx = kidx + 6'd1;
					next_kph  = (kph == nk - 4'd1) ? 4'd0 : kph + 4'd1;
					next_kq   = (kph == nk - 4'd1) ? kq + 4'd1 : kq;
				end else begin
					next_kidx = kidx - 6'd1;
					next_kph  = (kph == 4'd0) ? nk - 4'd1 : kph - 4'd1;
					next_kq   = (kph == 4'd0) ? kq - 4'd1 : kq;
				end
				if (exp_last) begin
					next_state = st_round;
					next_rnd   = 4'd0;
				end
			end
			st_round: begin
				next_cs  = enc ? enc_next : dec_next;
				next_rnd = rnd + 4'd1;
				if (rnd == nr) begin
					next_state   = st_unload;
					next_out_cnt = 5'd0;
				end
			end
			st_unload: begin
				if (push_rdy) next_out_cnt = out_cnt + 5'd1;
				if (blk_done) begin
					next_state    = st_load;
					next_data_cnt = 5'd0;
					next_key_cnt  = 6'd0;
				end
			end
			default: next_state = st_idle;
		endcase
		if (!en) next_state = st_idle;
	end

	wire next_blk_req = loading & (data_cnt < `AEC_BLOCK_BYTES)
		& ({1'b0, data_cnt} <= key_cnt) & ~blk_take;
	wire next_key_req = loading & (key_cnt < klen)
		& (({1'b0, data_cnt} > key_cnt) | (data_cnt == `AEC_BLOCK_BYTES)) & ~key_take;

	// -----------------------------------------------------------
	// registers
	// -----------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst | soft_rst) begin
			state    <= st_idle;
			data_cnt <= 5'd0;
			key_cnt  <= 6'd0;
			out_cnt  <= 5'd0;
			kidx     <= 6'd0;
			kph      <= 4'd0;
			kq       <= 4'd0;
			rnd      <= 4'd0;
			cs       <= '0;
		end else begin
			state    <= next_state;
			data_cnt <= next_data_cnt;
			key_cnt  <= next_key_cnt;
			out_cnt  <= next_out_cnt;
			kidx     <= next_kidx;
			kph      <= next_kph;
			kq       <= next_kq;
			rnd      <= next_rnd;
			cs       <= next_cs;
		end
	end

	always_ff @(posedge mclk) begin
		if (key_take) begin
			kw[key_widx][8*(3 - key_cnt[1:0]) +: 8] <= key_data;
		end else if (state == st_expand) begin
			kw[kw_dst] <= kw_val;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ksz <= ks_128;
			enc <= 1'b0;
			en  <= 1'b0;
		end else if (cfg_wr) begin
			ksz <= aec_ksize_type'(cfg_wdata[`AEC_KSZ_MSB:`AEC_KSZ_LSB]);
			enc <= cfg_wdata[`AEC_DIR_BIT];
			en  <= cfg_wdata[`AEC_EN_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			done     <= 1'b0;
			done_irq <= 1'b0;
		end else begin
			done     <= blk_done | (done & ~soft_rst & ~new_block);
			done_irq <= blk_done;
		end
	end

	// view of the configuration register, one clock behind
	logic [7:0] cfg_view;
	always_comb begin
		cfg_view = `AEC_CFG_RESET;
		cfg_view[`AEC_KSZ_MSB:`AEC_KSZ_LSB] = ksz;
		cfg_view[`AEC_DIR_BIT] = enc;
		cfg_view[`AEC_EN_BIT] = en;
		cfg_view[`AEC_DONE_BIT] = done;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_rdata   <= `AEC_CFG_RESET;
			dflow_rdata <= `AEC_DFLOW_ECB;
			key_req     <= 1'b0;
			blk_req     <= 1'b0;
		end else begin
			cfg_rdata   <= cfg_view;
			dflow_rdata <= dflow_wr ? dflow_wdata : dflow_rdata;
			key_req     <= next_key_req & ~soft_rst;
			blk_req     <= next_blk_req & ~soft_rst;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst | soft_rst) begin
			res_full <= 1'b0;
			res_data <= 8'h00;
		end else begin
			res_full <= res_load | (res_full & ~res_pop);
			res_data <= res_load ? fifo_data : res_data;
		end
	end

	assign res_req = res_full;
endmodule

// ===== src/aec_consts.svh
// constants for the block-cipher engine
`ifndef AEC_CONSTS_SVH
`define AEC_CONSTS_SVH

// ---------------------------------------------------------------
// block configuration register fields
// ---------------------------------------------------------------
`define AEC_KSZ_LSB        0
`define AEC_KSZ_MSB        1
`define AEC_DIR_BIT        2
`define AEC_EN_BIT         3
`define AEC_DONE_BIT       5
`define AEC_SOFT_RESET     8'h00
`define AEC_CFG_RESET      8'h00

// ---------------------------------------------------------------
// data-flow configuration
// ---------------------------------------------------------------
`define AEC_DFLOW_ECB      8'h00

// ---------------------------------------------------------------
// block and key geometry
// ---------------------------------------------------------------
`define AEC_BLOCK_BYTES    5'd16
`define AEC_LAST_BYTE      5'd15
`define AEC_KEY_WORDS      60
`define AEC_NK_128         4'd4
`define AEC_NK_192         4'd6
`define AEC_NK_256         4'd8
`define AEC_NR_128         4'd10
`define AEC_NR_192         4'd12
`define AEC_NR_256         4'd14
`define AEC_TW_128         6'd44
`define AEC_TW_192         6'd52
`define AEC_TW_256         6'd60
`define AEC_DQ_128         4'd10
`define AEC_DQ_192         4'd8
`define AEC_DQ_256         4'd7
`define AEC_DEC_PHASE      4'd3
`define AEC_SUB_PHASE      4'd4

// ---------------------------------------------------------------
// field arithmetic
// ---------------------------------------------------------------
`define AEC_POLY           8'h1b
`define AEC_FWD_AFFINE     8'h63
`define AEC_INV_AFFINE     8'h05
`define AEC_INV_EXP        8'hfe
`define AEC_RCON_INIT      8'h01
`define AEC_M1             8'h01
`define AEC_M2             8'h02
`define AEC_M3             8'h03
`define AEC_M9             8'h09
`define AEC_MB             8'h0b
`define AEC_MD             8'h0d
`define AEC_ME             8'h0e

// ---------------------------------------------------------------
// result buffer
// ---------------------------------------------------------------
`define AEC_FIFO_WIDTH     8
`define AEC_FIFO_DEPTH     32

`endif

// ===== src/aec_pkg.sv
// types shared by the block-cipher engine
package aec_pkg;
	typedef enum logic [2:0] {
		st_idle   = 3'b000,
		st_load   = 3'b001,
		st_expand = 3'b011,
		st_round  = 3'b010,
		st_unload = 3'b110
	} aec_state_type;

	typedef enum logic [1:0] {
		ks_128  = 2'b00,
		ks_192  = 2'b01,
		ks_256  = 2'b10,
		ks_rsvd = 2'b11
	} aec_ksize_type;
endpackage

// ===== src/aec_top_unused_placeholder.sv
// intentionally minimal: no further logic
`timescale 1ns/100ps

// ===== verif/aec_engine_checker.sv
// port assertions for the block-cipher engine
`timescale 1ns/100ps
module aec_engine_checker (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       cfg_wr,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata,
	input wire logic       dflow_wr,
	input wire logic [7:0] dflow_wdata,
	input wire logic [7:0] dflow_rdata,
	input wire logic       key_wr,
	input wire logic [7:0] key_data,
	input wire logic       blk_wr,
	input wire logic [7:0] blk_data,
	input wire logic       res_rd,
	input wire logic [7:0] res_data,
	input wire logic       res_req,
	input wire logic       key_req,
	input wire logic       blk_req,
	input wire logic       done_irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	chk_req_excl: assert property (!(key_req && blk_req))
		else $error("key and block requests high together");
	chk_blk_drop: assert property (blk_wr && blk_req |=> !blk_req)
		else $error("block request held after a take");
	chk_key_drop: assert property (key_wr && key_req |=> !key_req)
		else $error("key request held after a take");
	chk_cfg_echo: assert property (
		cfg_wr ##1 !cfg_wr |-> ##1 cfg_rdata[3:0] == $past(cfg_wdata[3:0], 2))
		else $error("config fields not kept");
	chk_soft_clear: assert property (
		cfg_wr && cfg_wdata == 8'h00 ##1 !cfg_wr |-> ##1 cfg_rdata == 8'h00)
		else $error("soft reset left config set");
	chk_soft_idle: assert property (
		cfg_wr && cfg_wdata == 8'h00 |-> ##2 !(key_req || blk_req || res_req))
		else $error("requests after soft reset");
	chk_irq_pulse: assert property (done_irq |=> !done_irq)
		else $error("done pulse too long");
	chk_done_bit: assert property (done_irq && !cfg_wr |=> cfg_rdata[5])
		else $error("done bit not set");
	chk_done_res: assert property (done_irq |-> ##[0:2] res_req)
		else $error("no result after done");
	chk_flow_take: assert property (dflow_wr |=> dflow_rdata == $past(dflow_wdata))
		else $error("data-flow value not stored");
	chk_flow_hold: assert property (!dflow_wr |=> $stable(dflow_rdata))
		else $error("data-flow value changed");
endmodule

bind aec_engine aec_engine_checker chk (
	.mclk, .rst, .cfg_wr, .cfg_wdata, .cfg_rdata, .dflow_wr, .dflow_wdata, .dflow_rdata,
	.key_wr, .key_data, .blk_wr, .blk_data, .res_rd, .res_data, .res_req, .key_req,
	.blk_req, .done_irq
);

// ===== verif/aec_dma_model.sv
// byte mover standing in for the processor or dma channels
`timescale 1ns/100ps
module aec_dma_model (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         start,
	input  wire logic         slow,
	input  wire logic         hold,
	input  wire logic [255:0] key_vec,
	input  wire logic [5:0]   key_len,
	input  wire logic [127:0] blk_vec,
	input  wire logic         key_req,
	input  wire logic         blk_req,
	input  wire logic         res_req,
	input  wire logic [7:0]   res_data,
	output logic              key_wr,
	output logic      [7:0]   key_data,
	output logic              blk_wr,
	output logic      [7:0]   blk_data,
	output logic              res_rd,
	output logic      [127:0] res_vec,
	output logic      [7:0]   res_cnt
);
	logic [5:0] kc;
	logic [4:0] bc;
	logic [2:0] gap;

	initial begin
		key_wr = 1'b0;
		blk_wr = 1'b0;
		res_rd = 1'b0;
		key_data = 8'h00;
		blk_data = 8'h00;
	end

	// --------------------
	// paced transfers
	// --------------------
	// three streams: key in, block in, result out
	always @(negedge mclk) begin
		key_wr <= 1'b0;
		blk_wr <= 1'b0;
		res_rd <= 1'b0;
		// released lines flip so a stale byte never looks live
		if (key_wr)
			key_data <= ~key_data;
		if (blk_wr)
			blk_data <= ~blk_data;
		// key counts restart so the whole key goes again each block
		if (rst || start) begin
			kc <= 6'h00;
			bc <= 5'h00;
			gap <= 3'h0;
		end else if (gap != 3'h0)
			gap <= gap - 3'h1;
		else if (res_req && !hold) begin
			res_rd <= 1'b1;
			res_vec <= {res_vec[119:0], res_data};
			res_cnt <= res_cnt + 8'h01;
			gap <= 3'h2;
		// data byte only on request, sixteen per block
		end else if (blk_req && bc != 5'h10) begin
			blk_wr <= 1'b1;
			blk_data <= blk_vec[127 - 8 * bc -: 8];
			bc <= bc + 5'h1;
			gap <= slow ? 3'h6 : 3'h2;
		// key bytes one at a time up to the key length
		end else if (key_req && kc != key_len) begin
			key_wr <= 1'b1;
			key_data <= key_vec[255 - 8 * kc -: 8];
			kc <= kc + 6'h01;
			gap <= slow ? 3'h6 : 3'h2;
		end
		if (rst)
			res_cnt <= 8'h00;
	end
endmodule

// ===== verif/testbench.sv
// self-checking bench for the block-cipher engine
`timescale 1ns/100ps
module testbench;
	localparam logic [127:0] pt = 128'h00112233445566778899aabbccddeeff;
	localparam logic [127:0] k128 = 128'h000102030405060708090a0b0c0d0e0f;
	localparam logic [191:0] k192 = {k128, 64'h1011121314151617};
	localparam logic [255:0] k256 = {k128, 128'h101112131415161718191a1b1c1d1e1f};
	localparam logic [127:0] dk128 = 128'h13111d7fe3944a17f307a78b4d2b30c5;
	localparam logic [127:0] ct128 = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
	localparam logic [127:0] ct192 = 128'hdda97ca4864cdfe06eaf70a0ec0d7191;
	localparam logic [127:0] ct256 = 128'h8ea2b7ca516745bfeafc49904b496089;

	logic mclk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, dflow_wr = 1'b0;
	logic [7:0] cfg_wdata = 8'h00, dflow_wdata = 8'h00;
	logic start = 1'b0, slow = 1'b0, hold = 1'b0;
	logic [255:0] key_vec = '0;
	logic [5:0] key_len = 6'd16;
	logic [127:0] blk_vec = '0, res_vec;
	logic [7:0] cfg_rdata, dflow_rdata, res_data, key_data, blk_data, res_cnt, base;
	logic res_req, key_req, blk_req, done_irq, key_wr, blk_wr, res_rd;
	int err_total = 0, tests_run = 0, cycles = 0, done_cnt = 0, d0;

	aec_engine dut (.mclk, .rst, .cfg_wr, .cfg_wdata, .cfg_rdata, .dflow_wr, .dflow_wdata,
		.dflow_rdata, .key_wr, .key_data, .blk_wr, .blk_data, .res_rd, .res_data, .res_req,
		.key_req, .blk_req, .done_irq);
	aec_dma_model far (.mclk, .rst, .start, .slow, .hold, .key_vec, .key_len, .blk_vec,
		.key_req, .blk_req, .res_req, .res_data, .key_wr, .key_data, .blk_wr, .blk_data,
		.res_rd, .res_vec, .res_cnt);

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	// --------------------
	// helpers
	// --------------------
	task wrap_up;
		begin
			if (err_total == 0 && tests_run > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask

	task check(input string name, input logic [127:0] exp, input logic [127:0] got);
		begin
			tests_run++;
			if (got !== exp) begin
				$display("ERROR %s expected %h seen %h", name, exp, got);
				err_total++;
			end
		end
	endtask

	// sel high writes the data-flow register, low the block config
	task reg_write(input logic sel, input logic [7:0] val);
		begin
			@(negedge mclk);
			cfg_wr <= !sel;
			dflow_wr <= sel;
			cfg_wdata <= val;
			dflow_wdata <= val;
			@(negedge mclk);
			cfg_wr <= 1'b0;
			dflow_wr <= 1'b0;
		end
	endtask

	task feed;
		begin
			start <= 1'b1;
			@(negedge mclk);
			start <= 1'b0;
		end
	endtask

	task wait_res(input logic [7:0] target);
		begin
			while (res_cnt !== target)
				@(negedge mclk);
		end
	endtask

	task run_block(input logic [7:0] m, input logic [255:0] k, input logic [5:0] n,
			input logic [127:0] d, input logic [127:0] e, input logic s);
		begin
			reg_write(1'b0, 8'h00);
			reg_write(1'b1, 8'h00);
			// mover restarted before enabling: stale counts would send wrong bytes
			key_vec <= k;
			key_len <= n;
			blk_vec <= d;
			slow <= s;
			base = res_cnt;
			feed;
			reg_write(1'b0, m);
			repeat (2) @(negedge mclk);
			check("config", {120'h0, m}, {120'h0, cfg_rdata});
			wait_res(base + 8'h10);
			check("result", e, res_vec);
			check("done flag", 128'h1, {127'h0, cfg_rdata[5]});
		end
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (done_irq === 1'b1)
			done_cnt <= done_cnt + 1;
		if (cycles == 20000) begin
			err_total++;
			wrap_up;
		end
	end

	// --------------------
	// main sequence
	// --------------------
	initial begin
		repeat (4) @(negedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		check("config reset", 128'h0, {120'h0, cfg_rdata});
		check("flow reset", 128'h0, {120'h0, dflow_rdata});
		reg_write(1'b1, 8'h5a);
		check("flow store", 128'h5a, {120'h0, dflow_rdata});
		// a partial block must be thrown away by the soft reset that follows
		key_vec <= {k128, 128'h0};
		blk_vec <= pt;
		reg_write(1'b0, 8'h0c);
		feed;
		repeat (20) @(negedge mclk);
		run_block(8'h0c, {k128, 128'h0}, 6'd16, pt, ct128, 1'b0);
		run_block(8'h0d, {k192, 64'h0}, 6'd24, pt, ct192, 1'b0);
		run_block(8'h0e, k256, 6'd32, pt, ct256, 1'b1);
		run_block(8'h0f, {k128, 128'h0}, 6'd16, pt, ct128, 1'b0);
		run_block(8'h08, {dk128, 128'h0}, 6'd16, ct128, pt, 1'b1);
		// results held back: two blocks fill the buffer, the third stalls
		hold <= 1'b1;
		slow <= 1'b0;
		base = res_cnt;
		d0 = done_cnt;
		for (int i = 0; i < 3; i++) begin
			feed;
			repeat (300) @(negedge mclk);
		end
		check("stalled blocks", 128'd2, 128'(done_cnt - d0));
		hold <= 1'b0;
		for (int i = 1; i < 4; i++) begin
			wait_res(base + 8'(16 * i));
			check("queued result", pt, res_vec);
		end
		check("queued blocks", 128'd3, 128'(done_cnt - d0));
		reg_write(1'b0, 8'h00);
		repeat (2) @(negedge mclk);
		check("config cleared", 128'h0, {120'h0, cfg_rdata});
		check("requests idle", 128'h0, {125'h0, key_req, blk_req, res_req});
		wrap_up;
	end
endmodule
